// file: dv/csp_host_model.sv
// Bus controller model that drives the two-wire and three-wire control port
`timescale 1ns/1ns
`default_nettype none
module csp_host_model (
    input wire logic i_sda,
    input wire logic i_rb_pin,
    input wire logic i_rb_oe_n,
    output logic o_scl,
    output logic o_sda,
    output logic o_cs
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_cs = 1'b1;
    end

    // Data is released first so that the fall always lands with the clock high
    task automatic start_cond();
        o_sda = 1'b1;
        #40 o_scl = 1'b1;
        #40 o_sda = 1'b0;
        #80 o_scl = 1'b0;
    endtask : start_cond

    // Slots are data bits and acknowledge clocks; fewer than 27 cut the frame short
    task automatic xfer(input logic [23:0] bits, input int slots, input bit restart,
        output logic [2:0] acks, output logic [7:0] rb);
        int k;
        acks = 3'b111;
        rb = 8'h00;
        #3 start_cond();
        for (int s = 0; s < slots; s++) begin
            k = s / 9;
            if (s % 9 == 8) o_sda = 1'b1;
            else o_sda = bits[23 - (s - k)];
            #40;
            // Readback bits are taken at the rise, before the device reacts to it
            if (k == 2 && s % 9 != 8) rb[25 - s] = i_rb_oe_n ? 1'bz : i_rb_pin;
            o_scl = 1'b1;
            #40;
            if (s % 9 == 8) acks[2 - k] = i_sda;
            #40 o_scl = 1'b0;
            #40;
        end
        if (restart) begin
            start_cond();
        end else begin
            o_sda = 1'b0;
            #40 o_scl = 1'b1;
            #40 o_sda = 1'b1;
            #80;
        end
    endtask : xfer

    task automatic spi_word(input logic [15:0] w, output logic [7:0] rb);
        rb = 8'h00;
        #3 o_scl = 1'b0;
        #80 o_cs = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            o_sda = w[i];
            #80;
            // Readback bit launched at the previous rise, taken before this one
            if (i < 8) rb[i] = i_rb_oe_n ? 1'bz : i_rb_pin;
            o_scl = 1'b1;
            #80 o_scl = 1'b0;
        end
        #80 o_cs = 1'b1;
        #80 o_scl = 1'b1;
        o_sda = 1'b1;
    endtask : spi_word
endmodule : csp_host_model
`default_nettype wire

// file: dv/csp_serial_port_bench.sv
// Self-checking bench for the serial control port
`timescale 1ns/1ns
`default_nettype none
module csp_serial_port_bench;
    import csp_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic hw = 1'b0;
    logic mode = 1'b0;
    logic cs = 1'b0;
    csp_status_s status = '0;
    wire logic scl, host_sda, host_cs, sda, sda_out, sda_oe_n, rb_pin, rb_oe_n;
    wire logic cmd_valid, pd;
    csp_cmd_s cmd, last_cmd;
    int miscompares = 0;
    int check_count = 0;
    int cmd_seen = 0;
    logic [7:0] rb;
    logic [2:0] acks;
    logic [15:0] w;
    logic [8:0] d;
    logic [6:0] dev;

    // Open-drain data line with a pull-up: either party pulls it low
    assign sda = host_sda & (sda_oe_n ? 1'b1 : sda_out);

    always #5 i_clk = ~i_clk;

    csp_host_model csp_host_model_inst (.i_sda(sda), .i_rb_pin(rb_pin),
        .i_rb_oe_n(rb_oe_n), .o_scl(scl), .o_sda(host_sda), .o_cs(host_cs));

    csp_serial_port csp_serial_port_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_link_clk(scl), .i_serial_clock_pin(scl), .i_serial_data_line(sda),
        .i_chip_select_pin(mode ? host_cs : cs), .i_wire_count_select_pin(mode),
        .i_hardware_control_select_pin(hw), .i_status(status),
        .o_serial_data_line(sda_out), .o_serial_data_line_oe_n(sda_oe_n),
        .o_readback_output_pin(rb_pin), .o_readback_output_pin_oe_n(rb_oe_n),
        .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_powered_down(pd));

    always @(posedge i_clk) begin
        if (cmd_valid === 1'b1) begin
            cmd_seen++;
            last_cmd <= cmd;
        end
    end

    task automatic compare(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : compare

    task automatic complete_run();
        if (miscompares == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // Register writes kept away from power, readback and reset offsets
    function automatic logic [15:0] rand_cmd();
        return {3'h1, 4'($urandom()), 9'($urandom())};
    endfunction : rand_cmd

    function automatic logic [7:0] pick(input csp_status_s s, input logic [2:0] sel);
        if (sel == 3'h0) return s.error;
        if (sel == 3'h7) return 8'h00;
        if (sel == 3'h6) return s.rx_status;
        return s.chan[sel - 3'h1];
    endfunction : pick

    // exp_cmd 2 leaves the command pulse unchecked
    task automatic frame(input logic [6:0] a, input logic [15:0] cw, input bit exp_ack,
        input int exp_cmd);
        int n0;
        n0 = cmd_seen;
        csp_host_model_inst.xfer({a, 1'b0, cw}, 27, 1'b0, acks, rb);
        repeat (8) @(posedge i_clk);
        compare("ack", exp_ack ? 16'h0000 : 16'h0007, {13'h0, acks});
        if (exp_cmd < 2) compare("cmd count", 16'(exp_cmd), 16'(cmd_seen - n0));
        if (exp_cmd == 1) compare("cmd", cw, last_cmd);
    endtask : frame

    initial begin
        #400_000;
        miscompares++;
        complete_run();
    end

    initial begin
        void'($urandom(80));
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (5) @(posedge i_clk);
        compare("powered down", 16'h1, {15'h0, pd});
        compare("sda oe_n", 16'h1, {15'h0, sda_oe_n});
        for (int c = 0; c < 2; c++) begin
            cs <= c[0];
            for (int j = 0; j < 2; j++) begin
                frame(j ? CSP_ADDR_CS_HIGH : CSP_ADDR_CS_LOW, rand_cmd(), c == j, c == j);
            end
        end
        cs <= 1'b0;
        dev = CSP_ADDR_CS_LOW;
        frame(7'h55, rand_cmd(), 1'b0, 0);
        frame(dev, rand_cmd(), 1'b1, 1);
        frame(dev, {CSP_REG_POWER, 9'h1ff}, 1'b1, 1);
        compare("powered down", 16'h0, {15'h0, pd});
        frame(dev, {CSP_REG_SW_RESET, 9'($urandom())}, 1'b1, 2);
        compare("powered down", 16'h1, {15'h0, pd});
        w = rand_cmd();
        d = 9'(cmd_seen);
        csp_host_model_inst.xfer({dev, 1'b0, w}, 20, 1'b0, acks, rb);
        repeat (8) @(posedge i_clk);
        compare("cmd after stop", 16'(d), 16'(cmd_seen));
        d = 9'(cmd_seen);
        csp_host_model_inst.xfer({dev, 1'b0, w}, 12, 1'b1, acks, rb);
        repeat (8) @(posedge i_clk);
        compare("cmd after abort", 16'(d), 16'(cmd_seen));
        frame(dev, w, 1'b1, 1);
        for (int sel = 0; sel < 8; sel++) begin
            status <= 56'({$urandom(), $urandom()});
            frame(dev, {CSP_REG_READBACK, 9'h018 | 9'(sel)}, 1'b1, 1);
            frame(dev, rand_cmd(), 1'b1, 1);
            compare("readback", 16'(pick(status, 3'(sel))), {8'h0, rb});
        end
        d = 9'($urandom()) | 9'h001;
        frame(dev, {CSP_REG_POWER, d}, 1'b1, 1);
        frame(dev, {CSP_REG_READBACK, 9'h010}, 1'b1, 1);
        frame(dev, {CSP_REG_POWER, 9'h000}, 1'b1, 0);
        compare("readback", 16'(d[7:0]), {8'h0, rb});
        compare("powered down", 16'h0, {15'h0, pd});
        frame(dev, {CSP_REG_READBACK, 9'h000}, 1'b1, 1);
        hw <= 1'b1;
        repeat (5) @(posedge i_clk);
        frame(dev, rand_cmd(), 1'b0, 0);
        hw <= 1'b0;
        mode <= 1'b1;
        repeat (5) @(posedge i_clk);
        d = 9'(cmd_seen);
        w = rand_cmd();
        csp_host_model_inst.spi_word(w, rb);
        repeat (8) @(posedge i_clk);
        compare("spi cmd count", 16'(d) + 16'h1, 16'(cmd_seen));
        compare("spi cmd", w, last_cmd);
        status <= 56'({$urandom(), $urandom()});
        csp_host_model_inst.spi_word({CSP_REG_READBACK, 9'h01e}, rb);
        repeat (8) @(posedge i_clk);
        csp_host_model_inst.spi_word(rand_cmd(), rb);
        repeat (8) @(posedge i_clk);
        compare("spi readback", 16'(pick(status, 3'h6)), {8'h0, rb});
        mode <= 1'b0;
        repeat (5) @(posedge i_clk);
        frame(dev, rand_cmd(), 1'b1, 1);
        complete_run();
    end
endmodule : csp_serial_port_bench
`default_nettype wire

// file: src/csp_pkg.sv
// Constants and types shared by the serial control port
package csp_pkg;
    localparam logic [6:0] CSP_ADDR_CS_LOW = 7'h1a;
    localparam logic [6:0] CSP_ADDR_CS_HIGH = 7'h1b;
    localparam logic [6:0] CSP_REG_POWER = 7'h32;
    localparam logic [6:0] CSP_REG_READBACK = 7'h34;
    localparam logic [6:0] CSP_REG_SW_RESET = 7'h35;
    localparam logic [8:0] CSP_REG_DEFAULT = 9'h000;
    localparam int CSP_SEL_LSB = 0;
    localparam int CSP_CONT_BIT = 3;
    localparam int CSP_RDEN_BIT = 4;
    localparam logic [2:0] CSP_SEL_ERROR = 3'h0;
    localparam logic [2:0] CSP_BIT_LAST = 3'h7;
    localparam logic [4:0] CSP_LINK_BITS = 5'h10;

    typedef logic [7:0] csp_byte_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [8:0] data;
    } csp_cmd_s;

    typedef struct packed {
        csp_byte_t rx_status;
        csp_byte_t [4:0] chan;
        csp_byte_t error;
    } csp_status_s;

    typedef enum logic [7:0] {
        CSP_IDLE = 8'h01,
        CSP_ADDR = 8'h02,
        CSP_ACK_A = 8'h04,
        CSP_CMD_HI = 8'h08,
        CSP_ACK_HI = 8'h10,
        CSP_CMD_LO = 8'h20,
        CSP_ACK_LO = 8'h40,
        CSP_HOLD = 8'h80
    } csp_state_e;
endpackage : csp_pkg

// file: src/csp_reg_mem.sv
// Control register store with registered read port and bulk clear
`timescale 1ns/1ns
`default_nettype none
module csp_reg_mem
    import csp_pkg::*;
#(
    parameter int AW = 7,
    parameter int DW = 9
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clear,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata,
    output logic [DW-1:0] o_rb_ctrl,
    output logic [DW-1:0] o_power
);
    logic [DW-1:0] mem_q [2**AW];

    // Flops rather than RAM: a single-cycle clear of every word is needed
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= DW'(CSP_REG_DEFAULT);
            end
        end else if (i_clear) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= DW'(CSP_REG_DEFAULT);
            end
        end else if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem_q[i_raddr];
        end
    end

    assign o_rb_ctrl = mem_q[AW'(CSP_REG_READBACK)];
    assign o_power = mem_q[AW'(CSP_REG_POWER)];
endmodule : csp_reg_mem
`default_nettype wire

// file: src/csp_serial_port.sv
// Two-wire and three-wire serial control port with status readback
`timescale 1ns/1ns
`default_nettype none
module csp_serial_port
    import csp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_link_clk,
    input wire logic i_serial_clock_pin,
    input wire logic i_serial_data_line,
    input wire logic i_chip_select_pin,
    input wire logic i_wire_count_select_pin,
    input wire logic i_hardware_control_select_pin,
    input wire csp_status_s i_status,
    output logic o_serial_data_line,
    output logic o_serial_data_line_oe_n,
    output logic o_readback_output_pin,
    output logic o_readback_output_pin_oe_n,
    output logic o_cmd_valid,
    output csp_cmd_s o_cmd,
    output logic o_powered_down
);
    // Pin order: 0 clock, 1 data, 2 chip select, 3 wire count, 4 hardware mode
    logic [4:0] pin_m_q;
    logic [4:0] pin_s_q;
    logic [4:0] pin_p_q;
    logic scl;
    logic sda;
    logic scl_p;
    logic sda_p;
    logic cs;
    logic cs_p;
    logic two_wire;
    logic three_wire;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    csp_state_e state_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] hi_q;
    logic ack_drv_q;
    logic in_byte;
    logic in_ack;
    logic byte_done;
    logic [6:0] own_addr;
    logic rb_q;
    csp_byte_t rb_byte_q;
    csp_byte_t status_byte;
    logic cs_rise;
    logic [8:0] rb_ctrl;
    logic [8:0] power;
    logic [8:0] rdata;
    logic rd_en;
    logic cont;
    logic [2:0] sel;
    csp_cmd_s new_cmd;
    logic new_vld;
    logic is_read;
    logic [4:0] lcnt_q;
    logic [15:0] lshift_q;
    csp_byte_t lrb_m_q;
    csp_byte_t lrb_s_q;
    logic lrb_q;
    logic link_rst_n;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_m_q <= 5'h00;
            pin_s_q <= 5'h00;
            pin_p_q <= 5'h00;
        end else begin
            pin_m_q <= {i_hardware_control_select_pin, i_wire_count_select_pin,
                        i_chip_select_pin, i_serial_data_line, i_serial_clock_pin};
            pin_s_q <= pin_m_q;
            pin_p_q <= pin_s_q;
        end
    end

    assign scl = pin_s_q[0];
    assign sda = pin_s_q[1];
    assign cs = pin_s_q[2];
    assign scl_p = pin_p_q[0];
    assign sda_p = pin_p_q[1];
    assign cs_p = pin_p_q[2];
    assign two_wire = ~pin_s_q[4] & ~pin_s_q[3];
    assign three_wire = ~pin_s_q[4] & pin_s_q[3];
    assign scl_rise = scl & ~scl_p;
    assign scl_fall = ~scl & scl_p;
    assign start_c = two_wire & scl & scl_p & sda_p & ~sda;
    assign stop_c = two_wire & scl & scl_p & ~sda_p & sda;
    assign own_addr = cs ? CSP_ADDR_CS_HIGH : CSP_ADDR_CS_LOW;
    assign in_byte = state_q inside {CSP_ADDR, CSP_CMD_HI, CSP_CMD_LO};
    assign in_ack = state_q inside {CSP_ACK_A, CSP_ACK_HI, CSP_ACK_LO};
    assign shift_d = {shift_q[6:0], sda};
    assign byte_done = in_byte & scl_rise & (bit_q == CSP_BIT_LAST);

    assign rd_en = rb_ctrl[CSP_RDEN_BIT];
    assign cont = rb_ctrl[CSP_CONT_BIT];
    assign sel = rb_ctrl[CSP_SEL_LSB +: 3];

    // Protocol sequencer; a start anywhere restarts address reception
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= CSP_IDLE;
        end else if (!two_wire) begin
            state_q <= CSP_IDLE;
        end else if (start_c) begin
            state_q <= CSP_ADDR;
        end else if (stop_c) begin
            state_q <= CSP_IDLE;
        end else begin
            unique case (state_q)
                CSP_IDLE: begin
                end
                CSP_ADDR: begin
                    if (byte_done) begin
                        state_q <= (shift_d[7:1] == own_addr) ? CSP_ACK_A : CSP_IDLE;
                    end
                end
                CSP_ACK_A: begin
                    if (scl_fall && ack_drv_q) begin
                        state_q <= CSP_CMD_HI;
                    end
                end
                CSP_CMD_HI: begin
                    if (byte_done) begin
                        state_q <= CSP_ACK_HI;
                    end
                end
                CSP_ACK_HI: begin
                    if (scl_fall && ack_drv_q) begin
                        state_q <= CSP_CMD_LO;
                    end
                end
                CSP_CMD_LO: begin
                    if (byte_done) begin
                        state_q <= CSP_ACK_LO;
                    end
                end
                CSP_ACK_LO: begin
                    if (scl_fall && ack_drv_q) begin
                        state_q <= CSP_HOLD;
                    end
                end
                CSP_HOLD: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bit_q <= 3'h0;
            shift_q <= 8'h00;
        end else if (!in_byte || start_c) begin
            bit_q <= 3'h0;
        end else if (scl_rise) begin
            bit_q <= bit_q + 3'h1;
            shift_q <= shift_d;
        end
    end

    // Line held low from the fall after the eighth bit to the fall after the ninth
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ack_drv_q <= 1'b0;
        end else if (!in_ack || !two_wire || start_c || stop_c) begin
            ack_drv_q <= 1'b0;
        end else if (scl_fall) begin
            ack_drv_q <= ~ack_drv_q;
        end
    end

    assign o_serial_data_line = 1'b0;
    assign o_serial_data_line_oe_n = ~ack_drv_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hi_q <= 8'h00;
        end else if (state_q == CSP_CMD_HI && byte_done) begin
            hi_q <= shift_d;
        end
    end

    always_comb begin
        unique case (sel)
            3'h0: status_byte = i_status.error;
            3'h1: status_byte = i_status.chan[0];
            3'h2: status_byte = i_status.chan[1];
            3'h3: status_byte = i_status.chan[2];
            3'h4: status_byte = i_status.chan[3];
            3'h5: status_byte = i_status.chan[4];
            3'h6: status_byte = i_status.rx_status;
            default: status_byte = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rb_byte_q <= 8'h00;
        end else if (!(three_wire && !cs)) begin
            // Frozen while a three-wire frame is open, so the link side copies a settled byte
            rb_byte_q <= cont ? status_byte : rdata[7:0];
        end
    end

    // Readback bits change on clock falls so the host samples them on rises
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rb_q <= 1'b0;
        end else if (state_q == CSP_ACK_HI && scl_fall && ack_drv_q) begin
            rb_q <= rb_byte_q[7];
        end else if (state_q == CSP_CMD_LO && scl_fall && bit_q != 3'h0) begin
            rb_q <= rb_byte_q[CSP_BIT_LAST - bit_q];
        end
    end

    // Word from the link domain is still while select rises, so no resync;
    // a switch into three-wire mode with select already high is not a rise
    assign cs_rise = three_wire & ~pin_p_q[4] & pin_p_q[3] & cs & ~cs_p;

    always_comb begin
        new_vld = 1'b0;
        new_cmd = '0;
        if (state_q == CSP_CMD_LO && byte_done && !start_c && !stop_c) begin
            new_vld = 1'b1;
            new_cmd = {hi_q, shift_d};
        end else if (cs_rise) begin
            new_vld = 1'b1;
            new_cmd = lshift_q;
        end
    end

    assign is_read = rd_en & ~cont & (new_cmd.addr != CSP_REG_READBACK)
                     & (new_cmd.addr != CSP_REG_SW_RESET);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cmd_valid <= 1'b0;
            o_cmd <= '0;
        end else begin
            o_cmd_valid <= new_vld & ~is_read;
            if (new_vld) begin
                o_cmd <= new_cmd;
            end
        end
    end

    csp_reg_mem #(
        .AW(7),
        .DW(9)
    ) u_mem (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_clear(o_cmd_valid && o_cmd.addr == CSP_REG_SW_RESET),
        .i_we(o_cmd_valid && o_cmd.addr != CSP_REG_SW_RESET),
        .i_waddr(o_cmd.addr),
        .i_wdata(o_cmd.data),
        .i_raddr(hi_q[7:1]),
        .o_rdata(rdata),
        .o_rb_ctrl(rb_ctrl),
        .o_power(power)
    );

    assign o_powered_down = (power == CSP_REG_DEFAULT);

    // Link domain: three-wire framing, clocked by the host serial clock
    assign link_rst_n = i_reset_n & ~i_chip_select_pin;

    always_ff @(posedge i_link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lcnt_q <= 5'h00;
        end else if (lcnt_q != CSP_LINK_BITS) begin
            lcnt_q <= lcnt_q + 5'h01;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lshift_q <= 16'h0000;
        end else if (!i_chip_select_pin) begin
            lshift_q <= {lshift_q[14:0], i_serial_data_line};
        end
    end

    always_ff @(posedge i_link_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lrb_m_q <= 8'h00;
            lrb_s_q <= 8'h00;
        end else begin
            lrb_m_q <= rb_byte_q;
            lrb_s_q <= lrb_m_q;
        end
    end

    always_ff @(posedge i_link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lrb_q <= 1'b0;
        end else if (lcnt_q >= 5'h07 && lcnt_q < 5'h0f) begin
            lrb_q <= lrb_s_q[3'h6 - lcnt_q[2:0]];
        end
    end

    assign o_readback_output_pin = two_wire ? rb_q : lrb_q;
    assign o_readback_output_pin_oe_n =
        ~(rd_en & ((two_wire & state_q == CSP_CMD_LO) | (three_wire & ~cs)));

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    start_to_addr_a: assert property (start_c |=> state_q == CSP_ADDR)
        else $error("start not followed by address phase");
    stop_to_idle_a: assert property (stop_c && !start_c |=> state_q == CSP_IDLE)
        else $error("stop did not return to idle");
    addr_hit_a: assert property (state_q == CSP_ADDR && byte_done && !start_c && !stop_c
        && shift_d[7:1] == own_addr |=> state_q == CSP_ACK_A)
        else $error("own address not acknowledged");
    addr_miss_a: assert property (state_q == CSP_ADDR && byte_done && !start_c && !stop_c
        && shift_d[7:1] != own_addr |=> state_q == CSP_IDLE ##1 o_serial_data_line_oe_n)
        else $error("foreign address not ignored");
    ack_scope_a: assert property (!o_serial_data_line_oe_n |-> in_ack)
        else $error("data line driven outside acknowledge");
    ack_release_a: assert property (ack_drv_q && scl_fall |=> o_serial_data_line_oe_n)
        else $error("data line not released after acknowledge clock");
    cmd_issue_a: assert property (state_q == CSP_CMD_LO && byte_done && !start_c
        && !stop_c && !is_read |=> o_cmd_valid && o_cmd.data[7:0] == $past(shift_d))
        else $error("command word not issued");
    sw_reset_a: assert property (o_cmd_valid && o_cmd.addr == CSP_REG_SW_RESET
        |=> o_powered_down && rb_ctrl == CSP_REG_DEFAULT)
        else $error("software reset left registers set");
    status_sel_a: assert property (cont && sel == CSP_SEL_ERROR && !(three_wire && !cs)
        |=> rb_byte_q == $past(i_status.error))
        else $error("error register not selected");
    rb_first_a: assert property (state_q == CSP_ACK_HI && scl_fall && ack_drv_q && two_wire
        |=> o_readback_output_pin == $past(rb_byte_q[7]))
        else $error("readback byte not started with its top bit");
    hw_mode_a: assert property (pin_s_q[4] |=> state_q == CSP_IDLE)
        else $error("serial port active in hardware mode");
    rb_drive_a: assert property (rd_en && two_wire && state_q == CSP_CMD_LO
        |-> !o_readback_output_pin_oe_n)
        else $error("readback pin not driven");

    write_done_c: cover property (state_q == CSP_ACK_LO ##[1:40] state_q == CSP_HOLD);
    sw_reset_c: cover property (o_cmd_valid && o_cmd.addr == CSP_REG_SW_RESET);
    wire3_latch_c: cover property (cs_rise ##1 o_cmd_valid);
    miss_c: cover property (state_q == CSP_ADDR ##1 state_q == CSP_IDLE);
endmodule : csp_serial_port
`default_nettype wire
